// File: inc/cdr_map.svh
`ifndef CDR_MAP_SVH
`define CDR_MAP_SVH

// Clock and link timing, and the device address
`define CDR_CLK_PERIOD_NS 4
`define CDR_SCL_PERIOD_NS 160
`define CDR_SCL_QTR_CYC (`CDR_SCL_PERIOD_NS / `CDR_CLK_PERIOD_NS / 4)
`define CDR_MEAS_CYCLES 1000
`define CDR_SLAVE_ADDR 7'h40

// Device register sub addresses and reset value
`define CDR_OFS_RATE_LOCK 8'h08
`define CDR_OFS_FLAG_RESET 8'h09
`define CDR_OFS_OUTPUT_CFG 8'h11
`define CDR_CTRL_RESET 8'h00

// rate_and_lock_control fields
`define CDR_A_LOCK_REF 0
`define CDR_A_MEASURE 1
`define CDR_RATIO_REQUIRED 4'h5
// flag_and_reset_control fields
`define CDR_B_CLR_DONE 3
`define CDR_B_SYS_RESET 5
`define CDR_B_CLR_STATIC 6
`define CDR_B_CFG_LOL 7
`define CDR_B_WMASK 8'he8
`define CDR_B_PULSE_MASK 8'h68
// output_config_control fields
`define CDR_C_MUTE_MODE 1
`define CDR_C_LOS_POL 2
`define CDR_C_WMASK 8'h06

// Status bits
`define CDR_ST_DONE 2
`define CDR_ST_LOL 3
`define CDR_ST_STATIC 4
`define CDR_ST_LOS 5

// Lock detector thresholds
`define CDR_LOL_SET_PPM 16'd1000
`define CDR_LOL_CLR_PPM 16'd250

// Host AXI4-Lite register offsets and bits
`define CDR_H_CMD 4'h0
`define CDR_H_STAT 4'h4
`define CDR_H_IRQ 4'h8
`define CDR_H_MASK 4'hc
`define CDR_H_PULSE_BIT 16
`define CDR_IRQ_DONE 0
`define CDR_IRQ_NACK 1
`define CDR_RESP_OKAY 2'h0
`define CDR_RESP_SLVERR 2'h2
`endif

// File: inc/cdr_pkg.sv
`include "cdr_map.svh"
package cdr_pkg;
    typedef enum logic [1:0] {
        CDR_RX_IDLE = 2'b00,
        CDR_RX_RECV = 2'b01,
        CDR_RX_ACK = 2'b10
    } cdr_rx_e;

    typedef enum logic [1:0] {
        CDR_TX_IDLE = 2'b00,
        CDR_TX_START = 2'b01,
        CDR_TX_BITS = 2'b10,
        CDR_TX_STOP = 2'b11
    } cdr_tx_e;

    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] sync3;
        cdr_rx_e st;
        logic [3:0] bit_cnt;
        logic [1:0] byte_idx;
        logic [7:0] shift;
        logic [7:0] sub;
        logic sda_oe_n;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] ctrl_c;
        logic [15:0] meas_cnt;
        logic measuring;
        logic done;
        logic loss_of_lock_flag;
        logic lol_static;
        logic lol_pin;
        logic los_pin;
        logic mute_data;
        logic mute_clock;
    } cdr_dev_s;

    typedef struct packed {
        logic [1:0] sync;
        logic aw_got;
        logic w_got;
        logic [3:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] data;
        logic [7:0] sub;
        logic pulse;
        logic busy;
        logic [1:0] irq;
        logic [1:0] mask;
        cdr_tx_e st;
        logic [4:0] div;
        logic [1:0] phase;
        logic [3:0] bit_cnt;
        logic [1:0] byte_idx;
        logic nack;
        logic scl;
        logic sda_oe_n;
    } cdr_host_s;
endpackage

// File: inc/cdr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cdr_link_if;
    logic scl;
    logic host_sda_out;
    logic host_sda_oe_n;
    logic dev_sda_out;
    logic dev_sda_oe_n;
    logic sda;

    // Open-drain wire with pull-up: any enabled low driver wins
    assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

    modport host (output scl, output host_sda_out, output host_sda_oe_n, input sda);
    modport device (input scl, output dev_sda_out, output dev_sda_oe_n, input sda);
endinterface
`default_nettype wire

// File: src/cdr_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdr_map.svh"
module cdr_dev
    import cdr_pkg::*;
#(
    parameter int MEAS_CYCLES = `CDR_MEAS_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Serial link
    cdr_link_if.device link,
    // Front-end status
    input wire logic [15:0] i_freq_offset_ppm,
    input wire logic i_signal_lost,
    input wire logic i_mute,
    // Configuration to the analog core
    output logic [1:0] o_ref_range,
    output logic [3:0] o_rate_ratio,
    output logic o_ratio_ok,
    output logic o_lock_to_ref,
    output logic o_measuring,
    output logic o_system_reset,
    // Status and pins
    output logic [7:0] o_status,
    output logic o_loss_of_lock_flag,
    output logic o_loss_of_signal_flag,
    output logic o_mute_data,
    output logic o_mute_clock
);
    cdr_dev_s q;
    cdr_dev_s d;

    // Next state of the whole device
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic wr_a;
        logic wr_b;
        logic wr_c;
        logic meas_done;
        logic lol_rise;
        logic sys_rst;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c = 1'b0;
        stop_c = 1'b0;
        wr_a = 1'b0;
        wr_b = 1'b0;
        wr_c = 1'b0;
        meas_done = 1'b0;
        lol_rise = 1'b0;
        sys_rst = 1'b0;
        d = q;

        // Pins pass two flops; edges come from the second and third stages
        d.sync1 = {i_mute, i_signal_lost, link.scl, link.sda};
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        scl_rise = q.sync2[1] & ~q.sync3[1];
        scl_fall = ~q.sync2[1] & q.sync3[1];
        start_c = q.sync2[1] & q.sync3[1] & ~q.sync2[0] & q.sync3[0];
        stop_c = q.sync2[1] & q.sync3[1] & q.sync2[0] & ~q.sync3[0];

        // Receiver: address byte, sub address, then data with auto-increment
        case (q.st)
            CDR_RX_IDLE: begin
                d.sda_oe_n = 1'b1;
            end
            CDR_RX_RECV: begin
                if (scl_rise && q.bit_cnt < 4'd8) begin
                    d.shift = {q.shift[6:0], q.sync2[0]};
                    d.bit_cnt = q.bit_cnt + 4'h1;
                end
                if (scl_fall && q.bit_cnt == 4'd8) begin
                    d.st = CDR_RX_ACK;
                    d.sda_oe_n = 1'b0;
                    if (q.byte_idx == 2'd0) begin
                        // Reads are not served: every register here is write only
                        if (q.shift[7:1] != `CDR_SLAVE_ADDR || q.shift[0]) begin
                            d.st = CDR_RX_IDLE;
                            d.sda_oe_n = 1'b1;
                        end
                        d.byte_idx = 2'd1;
                    end else if (q.byte_idx == 2'd1) begin
                        d.sub = q.shift;
                        d.byte_idx = 2'd2;
                    end else begin
                        wr_a = (q.sub == `CDR_OFS_RATE_LOCK);
                        wr_b = (q.sub == `CDR_OFS_FLAG_RESET);
                        wr_c = (q.sub == `CDR_OFS_OUTPUT_CFG);
                        d.sub = q.sub + 8'h01;
                    end
                end
            end
            CDR_RX_ACK: begin
                if (scl_fall) begin
                    d.sda_oe_n = 1'b1;
                    d.st = CDR_RX_RECV;
                    d.bit_cnt = 4'h0;
                end
            end
            default: begin
                d.st = CDR_RX_IDLE;
                d.sda_oe_n = 1'b1;
            end
        endcase
        if (start_c) begin
            d.st = CDR_RX_RECV;
            d.bit_cnt = 4'h0;
            d.byte_idx = 2'd0;
            d.sda_oe_n = 1'b1;
        end else if (stop_c) begin
            d.st = CDR_RX_IDLE;
            d.sda_oe_n = 1'b1;
        end

        // Register writes; reserved bits are dropped so they stay zero
        if (wr_a) begin
            d.ctrl_a = q.shift;
        end
        if (wr_b) begin
            d.ctrl_b = q.shift & `CDR_B_WMASK;
        end
        if (wr_c) begin
            d.ctrl_c = q.shift & `CDR_C_WMASK;
        end

        // System reset is held for as long as the bit stays at 1
        sys_rst = q.ctrl_b[`CDR_B_SYS_RESET];

        // Measurement: each write carrying a 1 in the measure bit restarts it, except while system reset is held
        if (q.measuring) begin
            if (q.meas_cnt == 16'h0000) begin
                d.measuring = 1'b0;
                meas_done = 1'b1;
            end else begin
                d.meas_cnt = q.meas_cnt - 16'h0001;
            end
        end
        if (wr_a && q.shift[`CDR_A_MEASURE]) begin
            d.measuring = 1'b1;
            d.meas_cnt = 16'(MEAS_CYCLES - 1);
            d.done = 1'b0;
            meas_done = 1'b0;
        end
        // Clear is held while the pulse bit is 1, but a completion still lands
        if (meas_done) begin
            d.done = 1'b1;
        end else if (q.ctrl_b[`CDR_B_CLR_DONE] || sys_rst) begin
            d.done = 1'b0;
        end

        // Lock detector with hysteresis between the two thresholds
        if (i_freq_offset_ppm > `CDR_LOL_SET_PPM) begin
            d.loss_of_lock_flag = 1'b1;
        end else if (i_freq_offset_ppm <= `CDR_LOL_CLR_PPM) begin
            d.loss_of_lock_flag = 1'b0;
        end
        lol_rise = d.loss_of_lock_flag & ~q.loss_of_lock_flag;
        if (lol_rise) begin
            d.lol_static = 1'b1;
        end else if (q.ctrl_b[`CDR_B_CLR_STATIC] || sys_rst) begin
            d.lol_static = 1'b0;
        end
        if (sys_rst) begin
            d.measuring = 1'b0;
        end

        // Pin drivers, all registered
        d.lol_pin = q.ctrl_b[`CDR_B_CFG_LOL] ? q.lol_static : q.loss_of_lock_flag;
        d.los_pin = q.sync2[2] ^ q.ctrl_c[`CDR_C_LOS_POL];
        // In single mode only the data outputs are muted
        d.mute_data = q.sync2[3];
        d.mute_clock = q.sync2[3] & ~q.ctrl_c[`CDR_C_MUTE_MODE];
    end

    // State register; every control register starts at zero
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '0;
            q.sync1 <= 4'h3;
            q.sync2 <= 4'h3;
            q.sync3 <= 4'h3;
            q.sda_oe_n <= 1'b1;
            q.ctrl_a <= `CDR_CTRL_RESET;
            q.ctrl_b <= `CDR_CTRL_RESET;
            q.ctrl_c <= `CDR_CTRL_RESET;
        end else begin
            q <= d;
        end
    end

    // Outputs
    assign link.dev_sda_out = 1'b0;
    assign link.dev_sda_oe_n = q.sda_oe_n;
    assign o_ref_range = q.ctrl_a[7:6];
    assign o_rate_ratio = q.ctrl_a[5:2];
    assign o_ratio_ok = (q.ctrl_a[5:2] == `CDR_RATIO_REQUIRED);
    assign o_lock_to_ref = q.ctrl_a[`CDR_A_LOCK_REF];
    assign o_measuring = q.measuring;
    assign o_system_reset = q.ctrl_b[`CDR_B_SYS_RESET];
    assign o_status = {2'b00, q.sync3[2], q.lol_static, q.loss_of_lock_flag, q.done, 2'b00};
    assign o_loss_of_lock_flag = q.lol_pin;
    assign o_loss_of_signal_flag = q.los_pin;
    assign o_mute_data = q.mute_data;
    assign o_mute_clock = q.mute_clock;
endmodule
`default_nettype wire

// File: src/cdr_host.sv
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cdr_map.svh"
module cdr_host
    import cdr_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // AXI4-Lite write channels
    input wire logic [3:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read channels
    input wire logic [3:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Interrupt
    output logic o_irq,
    // Serial link
    cdr_link_if.host link
);
    cdr_host_s q;
    cdr_host_s d;

    // Forces the fixed ratio field and clears reserved bits before sending
    function automatic logic [7:0] clean(input logic [7:0] sub, input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (sub == `CDR_OFS_RATE_LOCK) begin
            r = {v[7:6], `CDR_RATIO_REQUIRED, v[1:0]};
        end else if (sub == `CDR_OFS_FLAG_RESET) begin
            r = v & `CDR_B_WMASK;
        end else if (sub == `CDR_OFS_OUTPUT_CFG) begin
            r = v & `CDR_C_WMASK;
        end
        return r;
    endfunction

    // Next state: bus slave plus serial write engine
    always_comb begin
        logic tick;
        logic [7:0] tx;
        logic [1:0] ev;
        tick = 1'b0;
        tx = 8'h00;
        ev = 2'b00;
        d = q;
        d.sync = {q.sync[0], link.sda};

        // Write address and data are taken in either order
        if (i_awvalid && o_awready) begin
            d.aw_got = 1'b1;
            d.awaddr = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            d.w_got = 1'b1;
            d.wdata = i_wdata;
            d.wstrb = i_wstrb; // Strobes belong to the data beat, so they are kept with it
        end
        if (q.aw_got && q.w_got) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `CDR_RESP_OKAY;
            case (q.awaddr)
                `CDR_H_CMD: begin
                    // A command while busy is dropped
                    if (!q.busy && q.wstrb != 4'h0) begin
                        d.data = clean(q.wdata[15:8], q.wdata[7:0]);
                        d.sub = q.wdata[15:8];
                        d.pulse = q.wdata[`CDR_H_PULSE_BIT];
                        d.busy = 1'b1;
                        d.st = CDR_TX_START;
                        d.div = 5'd0;
                        d.phase = 2'd0;
                    end
                end
                `CDR_H_STAT: begin
                end
                `CDR_H_IRQ: begin
                    d.irq = q.irq & ~q.wdata[1:0];
                end
                `CDR_H_MASK: begin
                    d.mask = q.wdata[1:0];
                end
                default: begin
                    d.bresp = `CDR_RESP_SLVERR;
                end
            endcase
        end
        if (q.bvalid && i_bready) begin
            d.bvalid = 1'b0;
        end
        if (i_arvalid && o_arready) begin
            d.rvalid = 1'b1;
            d.rresp = `CDR_RESP_OKAY;
            case (i_araddr)
                `CDR_H_CMD: d.rdata = {15'h0000, q.pulse, q.sub, q.data};
                `CDR_H_STAT: d.rdata = {31'h0, q.busy};
                `CDR_H_IRQ: d.rdata = {30'h0, q.irq};
                `CDR_H_MASK: d.rdata = {30'h0, q.mask};
                default: begin
                    d.rdata = 32'h00000000;
                    d.rresp = `CDR_RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && i_rready) begin
            d.rvalid = 1'b0;
        end

        // Quarter-period divider; runs only while a transfer is under way
        if (q.busy) begin
            if (q.div == 5'(`CDR_SCL_QTR_CYC - 1)) begin
                d.div = 5'd0;
                tick = 1'b1;
            end else begin
                d.div = q.div + 5'd1;
            end
        end
        case (q.byte_idx)
            2'd0: tx = {`CDR_SLAVE_ADDR, 1'b0};
            2'd1: tx = q.sub;
            default: tx = q.data;
        endcase

        if (tick) begin
            d.phase = q.phase + 2'd1;
            case (q.st)
                CDR_TX_START: begin
                    case (q.phase)
                        2'd0: begin
                            d.scl = 1'b1;
                            d.sda_oe_n = 1'b1;
                        end
                        2'd2: d.sda_oe_n = 1'b0;
                        2'd3: begin
                            d.scl = 1'b0;
                            d.st = CDR_TX_BITS;
                            d.byte_idx = 2'd0;
                            d.bit_cnt = 4'd0;
                            d.nack = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
                CDR_TX_BITS: begin
                    case (q.phase)
                        2'd0: d.sda_oe_n = (q.bit_cnt == 4'd8) ? 1'b1 : tx[3'(4'd7 - q.bit_cnt)];
                        2'd1: d.scl = 1'b1;
                        2'd2: begin
                            if (q.bit_cnt == 4'd8) begin
                                d.nack = q.sync[1];
                            end
                        end
                        default: begin
                            d.scl = 1'b0;
                            if (q.bit_cnt != 4'd8) begin
                                d.bit_cnt = q.bit_cnt + 4'd1;
                            end else if (q.nack || q.byte_idx == 2'd2) begin
                                d.st = CDR_TX_STOP;
                                ev[`CDR_IRQ_NACK] = q.nack;
                            end else begin
                                d.byte_idx = q.byte_idx + 2'd1;
                                d.bit_cnt = 4'd0;
                            end
                        end
                    endcase
                end
                CDR_TX_STOP: begin
                    case (q.phase)
                        2'd0: d.sda_oe_n = 1'b0;
                        2'd1: d.scl = 1'b1;
                        2'd2: d.sda_oe_n = 1'b1;
                        default: begin
                            // Pulse commands send the same value again with its pulse bits at 0
                            if (q.pulse && !q.nack) begin
                                d.pulse = 1'b0;
                                d.data = q.data & ~`CDR_B_PULSE_MASK;
                                d.st = CDR_TX_START;
                            end else begin
                                d.busy = 1'b0;
                                d.st = CDR_TX_IDLE;
                                ev[`CDR_IRQ_DONE] = 1'b1;
                            end
                        end
                    endcase
                end
                default: begin
                    d.st = CDR_TX_IDLE;
                end
            endcase
        end
        // An event in the cycle of its clear is kept
        d.irq = d.irq | ev;
    end

    // State register
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '0;
            q.sync <= 2'b11;
            q.scl <= 1'b1;
            q.sda_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs; measure and lock bits pass through as written
    assign o_awready = ~q.aw_got & ~q.bvalid;
    assign o_wready = ~q.w_got & ~q.bvalid;
    assign o_bvalid = q.bvalid;
    assign o_bresp = q.bresp;
    assign o_arready = ~q.rvalid;
    assign o_rvalid = q.rvalid;
    assign o_rdata = q.rdata;
    assign o_rresp = q.rresp;
    assign o_irq = |(q.irq & q.mask);
    assign link.scl = q.scl;
    assign link.host_sda_out = 1'b0;
    assign link.host_sda_oe_n = q.sda_oe_n;
endmodule
`default_nettype wire

// File: sim/cdr_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cdr_chk (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Link wires
    input wire logic scl,
    input wire logic host_sda_out,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe_n,
    input wire logic sda
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    // Open drain: a driven high would fight the pull-up
    property p_host_od; host_sda_out == 1'b0; endproperty
    a_host_od: assert property (p_host_od) else $error("host drives data high");
    property p_dev_od; dev_sda_out == 1'b0; endproperty
    a_dev_od: assert property (p_dev_od) else $error("device drives data high");
    // Clock halves last two quarters of ten cycles each
    property p_scl_hi; $rose(scl) |=> scl [*8]; endproperty
    a_scl_hi: assert property (p_scl_hi) else $error("clock high too short");
    property p_scl_lo; $fell(scl) |=> !scl [*8]; endproperty
    a_scl_lo: assert property (p_scl_lo) else $error("clock low too short");
    property p_scl_back; $fell(scl) |-> ##[1:40] scl; endproperty
    a_scl_back: assert property (p_scl_back) else $error("clock stuck low");
    // Acknowledge moves only while the clock is low, and must span its bit
    property p_ack_edge; $changed(dev_sda_oe_n) |-> !scl; endproperty
    a_ack_edge: assert property (p_ack_edge) else $error("ack moved with clock high");
    property p_ack_len; $fell(dev_sda_oe_n) |=> !dev_sda_oe_n [*8]; endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack too short");
    property p_ack_end; $fell(dev_sda_oe_n) |-> ##[1:60] dev_sda_oe_n; endproperty
    a_ack_end: assert property (p_ack_end) else $error("ack never released");
    property p_rst_idle; $rose(i_reset_n) |-> scl && host_sda_oe_n && dev_sda_oe_n && sda; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
    // Main link events
    c_ack: cover property ($fell(dev_sda_oe_n));
    c_start: cover property ($fell(sda) && scl);
    c_stop: cover property ($rose(sda) && scl);
endmodule
`default_nettype wire

// File: sim/cdr_control_registers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cdr_control_registers_tb_top
    import cdr_pkg::*;
;
    logic i_clock = 1'b0, i_reset_n = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, ref_range;
    logic [3:0] ratio;
    logic ratio_ok, lock_ref, measuring, sys_rst, lol_f, los_f, mute_d, mute_c;
    logic [7:0] status;
    logic [15:0] ppm = 16'h0;
    logic sig_lost = 1'b0, mute = 1'b0;
    logic [3:0] wstrb = 4'hf;
    int num_errors = 0, checks = 0, seed = 32'hc168;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    cdr_link_if link();
    cdr_host cdr_host_i (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .o_irq(irq), .link(link));
    // Short measurement keeps the run brief
    cdr_dev #(.MEAS_CYCLES(20)) cdr_dev_i (.i_clock(i_clock), .i_reset_n(i_reset_n), .link(link),
        .i_freq_offset_ppm(ppm), .i_signal_lost(sig_lost), .i_mute(mute), .o_ref_range(ref_range),
        .o_rate_ratio(ratio), .o_ratio_ok(ratio_ok), .o_lock_to_ref(lock_ref), .o_measuring(measuring),
        .o_system_reset(sys_rst), .o_status(status), .o_loss_of_lock_flag(lol_f),
        .o_loss_of_signal_flag(los_f), .o_mute_data(mute_d), .o_mute_clock(mute_c));
    cdr_chk cdr_chk_i (.i_clock(i_clock), .i_reset_n(i_reset_n), .scl(link.scl),
        .host_sda_out(link.host_sda_out), .host_sda_oe_n(link.host_sda_oe_n),
        .dev_sda_out(link.dev_sda_out), .dev_sda_oe_n(link.dev_sda_oe_n), .sda(link.sda));

    initial begin
        forever #2 i_clock = ~i_clock;
    end

    task automatic close_out();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t pin got %h expected %h", $time, got, exp);
        end
    endtask

    // Write: both channels offered together, each released when taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        bit ad, wd;
        ad = 0;
        wd = 0;
        exp_q.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge i_clock);
            if (!ad && awready) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge i_clock); while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [3:0] a, input logic [31:0] d);
        exp_q.push_back({2'h0, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge i_clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge i_clock); while (!rvalid);
        rready <= 1'b0;
    endtask

    // Device register write over the link, then mask and clear the done interrupt
    task automatic dw(input logic [7:0] sub, input logic [7:0] d, input logic p);
        axw(4'h0, {15'h0, p, sub, d}, 2'h0);
        axr(4'h4, 32'h1);
        // A command while busy must be dropped; the loop's readback catches a restart
        axw(4'h0, 32'h0, 2'h0);
        while (!irq) @(posedge i_clock);
        axr(4'h8, 32'h1);
        axw(4'hc, 32'h0, 2'h0);
        chk(irq, 0);
        axw(4'hc, 32'h3, 2'h0);
        chk(irq, 1);
        axw(4'h8, 32'h1, 2'h0);
        chk(irq, 0);
    endtask

    // Oldest note is compared with each bus answer as it appears
    always @(posedge i_clock) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            e = exp_q.pop_front();
            checks++;
            if (rvalid ? ({rresp, rdata} !== e) : (bresp !== e[33:32])) begin
                num_errors++;
                $display("MISMATCH %0t bus answer differs from %h", $time, e);
            end
        end
    end

    initial begin
        repeat (60000) @(posedge i_clock);
        num_errors++;
        close_out();
    end

    initial begin
        logic [1:0] r;
        repeat (20) @(posedge i_clock);
        i_reset_n <= 1'b1;
        @(posedge i_clock);
        chk({ref_range, ratio, lock_ref, sys_rst, status}, 0);
        chk({lol_f, los_f, mute_d, mute_c, measuring}, 0);
        axr(4'hc, 32'h0);
        axw(4'hc, 32'h3, 2'h0);
        axr(4'hc, 32'h3);
        axw(4'h6, 32'h0, 2'h2);
        // A command with no byte strobes starts nothing
        wstrb <= 4'h0;
        axw(4'h0, 32'h00010911, 2'h0);
        wstrb <= 4'hf;
        axr(4'h0, 32'h0);
        axr(4'h4, 32'h0);
        $display("test reset and host registers done");
        for (int i = 0; i < 4; i++) begin
            r = 2'(i);
            dw(8'h08, {r, 4'h0, 1'b1, r[0]}, 0);
            chk({ref_range, ratio, ratio_ok, lock_ref}, {r, 4'h5, 1'b1, r[0]});
            chk({measuring, status[2]}, 2'b01);
            axr(4'h0, {24'h000008, r, 4'h5, 1'b1, r[0]});
        end
        dw(8'h09, 8'h08, 1);
        chk(status[2], 0);
        $display("test range and measure done");
        @(posedge i_clock) ppm <= 16'd1001;
        repeat (6) @(posedge i_clock);
        chk({lol_f, status[4:3]}, 3'b111);
        ppm <= 16'd251 + 16'($random(seed) & 32'h1ff);
        repeat (6) @(posedge i_clock);
        chk(lol_f, 1);
        ppm <= 16'd250;
        repeat (6) @(posedge i_clock);
        chk({lol_f, status[4:3]}, 3'b010);
        dw(8'h09, 8'h80, 0);
        chk(lol_f, 1);
        dw(8'h09, 8'hc0, 1);
        chk({lol_f, status[4]}, 0);
        $display("test lock flags done");
        dw(8'h11, 8'h04, 0);
        chk(los_f, 1);
        sig_lost <= 1'b1;
        mute <= 1'b1;
        repeat (6) @(posedge i_clock);
        chk({los_f, status[5], mute_d, mute_c}, 4'b0111);
        dw(8'h11, 8'h06, 0);
        chk({mute_d, mute_c}, 2'b10);
        $display("test signal loss and mute done");
        dw(8'h09, 8'h20, 0);
        chk(sys_rst, 1);
        dw(8'h09, 8'h00, 0);
        chk(sys_rst, 0);
        $display("test system reset done");
        close_out();
    end
endmodule
`default_nettype wire
